// file: hdl/tms_select.sv
// trunk member selection and mirror copy generation for one lookup stream
`timescale 1ns/1ps
module tms_select
  import tms_pkg::*;
(
  input  wire logic        mclk_i,    // system clock
  input  wire logic        rstn_i,    // async reset, active low
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write
  input  wire logic [7:0]  wb_adr_i,  // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,  // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic      [31:0] wb_dat_o,  // wishbone read data
  output logic             wb_ack_o,  // wishbone acknowledge
  input  wire tms_req_t    req_i,     // lookup result from search engine
  output tms_resp_t        resp_o     // destination decision to queues
);

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------- register file ----------------
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [31:0]           mir_cfg;
  logic [63:0]           pgrp;
  logic [47:0]           flow_src;
  logic [47:0]           flow_dst;
  logic [31:0]           tbl [NGROUP];
  logic [15:0]           frame_cnt;
  logic [15:0]           drop_cnt;

  logic        bus_req;
  logic        wr_en;
  logic [31:0] ctrl_wr;
  logic [31:0] fsrc_hi_wr;
  logic [31:0] fdst_hi_wr;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = bus_req & wb_we_i;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // narrow registers merge lanes on a padded word, then keep their own bits
  assign ctrl_wr    = lane_merge({25'h0, ctrl}, wb_dat_i, wb_sel_i);
  assign fsrc_hi_wr = lane_merge({16'h0, flow_src[47:32]}, wb_dat_i,
                                 wb_sel_i);
  assign fdst_hi_wr = lane_merge({16'h0, flow_dst[47:32]}, wb_dat_i,
                                 wb_sel_i);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= RST_CTRL[CTRL_WIDTH-1:0];
      mir_cfg  <= RST_MIRROR;
      pgrp     <= {RST_PGRP, RST_PGRP};
      flow_src <= {RST_FLOW[15:0], RST_FLOW};
      flow_dst <= {RST_FLOW[15:0], RST_FLOW};
    end else if (wr_en) begin
      case (wb_adr_i)
        OFS_CTRL:    ctrl <= ctrl_wr[CTRL_WIDTH-1:0];
        OFS_MIRROR:  mir_cfg <= lane_merge(mir_cfg, wb_dat_i, wb_sel_i);
        OFS_PGRP_LO: pgrp[31:0] <= lane_merge(pgrp[31:0], wb_dat_i,
                                              wb_sel_i);
        OFS_PGRP_HI: pgrp[63:32] <= lane_merge(pgrp[63:32], wb_dat_i,
                                               wb_sel_i);
        OFS_FSRC_LO: flow_src[31:0] <= lane_merge(flow_src[31:0],
                                                  wb_dat_i, wb_sel_i);
        OFS_FSRC_HI: flow_src[47:32] <= fsrc_hi_wr[15:0];
        OFS_FDST_LO: flow_dst[31:0] <= lane_merge(flow_dst[31:0],
                                                  wb_dat_i, wb_sel_i);
        OFS_FDST_HI: flow_dst[47:32] <= fdst_hi_wr[15:0];
        default: begin
        end
      endcase
    end
  end

  // software rewrites entries here to move a failed member's share
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < NGROUP; g++) begin
        tbl[g] <= RST_TBL;
      end
    end else if (wr_en && wb_adr_i[7:5] == OFS_TBL[7:5]) begin
      tbl[wb_adr_i[4:2]] <= lane_merge(tbl[wb_adr_i[4:2]], wb_dat_i,
                                       wb_sel_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      if (wb_adr_i[7:5] == OFS_TBL[7:5]) begin
        wb_dat_o <= tbl[wb_adr_i[4:2]];
      end else begin
        case (wb_adr_i)
          OFS_CTRL:    wb_dat_o <= {25'h0, ctrl};
          OFS_MIRROR:  wb_dat_o <= mir_cfg;
          OFS_PGRP_LO: wb_dat_o <= pgrp[31:0];
          OFS_PGRP_HI: wb_dat_o <= pgrp[63:32];
          OFS_FSRC_LO: wb_dat_o <= flow_src[31:0];
          OFS_FSRC_HI: wb_dat_o <= {16'h0, flow_src[47:32]};
          OFS_FDST_LO: wb_dat_o <= flow_dst[31:0];
          OFS_FDST_HI: wb_dat_o <= {16'h0, flow_dst[47:32]};
          OFS_STATUS:  wb_dat_o <= {drop_cnt, frame_cnt};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------- hash key ----------------
  function automatic logic [2:0] fold48(input logic [47:0] v);
    logic [2:0] f;
    f = 3'h0;
    for (int i = 0; i < 16; i++) begin
      f = f ^ v[3*i +: 3];
    end
    return f;
  endfunction

  tms_hash_t  hash_sel;
  logic [2:0] key;

  assign hash_sel = tms_hash_t'(ctrl[CTRL_HASH_LSB +: 2]);

  // source port base only counts in ring mode; else falls back to both MACs
  always_comb begin
    case (hash_sel)
      TMS_HASH_BOTH: key = fold48(req_i.src_mac ^ req_i.dst_mac);
      TMS_HASH_SRC:  key = fold48(req_i.src_mac);
      TMS_HASH_DST:  key = fold48(req_i.dst_mac);
      TMS_HASH_PORT: begin
        key = ctrl[CTRL_RING] ? req_i.src_port[2:0]
                              : fold48(req_i.src_mac ^ req_i.dst_mac);
      end
      default:       key = 3'h0;
    endcase
  end

  // ---------------- group lookup ----------------
  logic [3:0] sel_port [NGROUP];
  logic       src_member;
  logic [2:0] src_grp;
  logic       dst_member;
  logic [2:0] dst_grp;

  generate
    for (genvar g = 0; g < NGROUP; g++) begin : g_sel
      assign sel_port[g] = tbl[g][4*key +: 4];
    end
  endgenerate

  assign src_member = pgrp[4*req_i.src_port + PGRP_MEMBER];
  assign src_grp    = pgrp[4*req_i.src_port +: 3];
  assign dst_member = pgrp[4*req_i.dst_port + PGRP_MEMBER];
  assign dst_grp    = pgrp[4*req_i.dst_port +: 3];

  // ---------------- multicast pruning, one slice per port ----------------
  logic [NPORT-1:0] mc_keep;

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_mc
      logic       mem_p;
      logic [2:0] grp_p;
      logic       same_grp;
      logic       chosen;
      assign mem_p    = pgrp[4*p + PGRP_MEMBER];
      assign grp_p    = pgrp[4*p +: 3];
      assign same_grp = src_member & mem_p & (grp_p == src_grp);
      assign chosen   = ~mem_p | (sel_port[grp_p] == 4'(p));
      assign mc_keep[p] = req_i.vlan_map[p]
                        & (req_i.src_port != 4'(p))
                        & ~same_grp
                        & chosen;
    end
  endgenerate

  // ---------------- unicast resolution ----------------
  logic             uc_drop;
  logic [3:0]       uc_port;
  logic [NPORT-1:0] base_dest;

  assign uc_drop = req_i.dst_trunk & dst_member & src_member
                 & (src_grp == dst_grp);
  assign uc_port = (req_i.dst_trunk & dst_member) ? sel_port[dst_grp]
                                                  : req_i.dst_port;

  assign base_dest = req_i.unicast ? (16'h0001 << uc_port) : mc_keep;

  // ---------------- mirroring ----------------
  logic [3:0]       m0_dst;
  logic [3:0]       m0_src;
  logic             m0_egr;
  logic [3:0]       m1_dst;
  logic [3:0]       m1_src;
  logic             m1_egr;
  logic             pm0_en;
  logic             pm1_en;
  logic [NPORT-1:0] mir_excl;
  logic [NPORT-1:0] norm_dest;
  logic             addr_hit;
  logic             flow_hit;
  logic             pm0_hit;
  logic             pm1_hit;
  logic [NPORT-1:0] mir_dest;
  logic             drop_now;

  assign m0_dst = mir_cfg[MIR_DST_LSB +: 4];
  assign m0_src = mir_cfg[MIR_SRC_LSB +: 4];
  assign m0_egr = mir_cfg[MIR_EGRESS];
  assign m1_dst = mir_cfg[MIR_SLOT + MIR_DST_LSB +: 4];
  assign m1_src = mir_cfg[MIR_SLOT + MIR_SRC_LSB +: 4];
  assign m1_egr = mir_cfg[MIR_SLOT + MIR_EGRESS];
  assign pm0_en = ctrl[CTRL_PM0_EN];
  assign pm1_en = ctrl[CTRL_PM1_EN];

  assign mir_excl = (pm0_en ? (16'h0001 << m0_dst) : 16'h0000)
                  | (pm1_en ? (16'h0001 << m1_dst) : 16'h0000);

  assign drop_now  = req_i.unicast & uc_drop;
  assign norm_dest = drop_now ? 16'h0000 : (base_dest & ~mir_excl);

  // side bit high means the address is matched as the frame's source
  assign addr_hit = (req_i.src_mirror & req_i.src_side)
                  | (req_i.dst_mirror & ~req_i.dst_side);

  assign flow_hit = (ctrl[CTRL_FLOW_EN]
                     & (req_i.src_mac == flow_src)
                     & (req_i.dst_mac == flow_dst))
                  | (ctrl[CTRL_FLOW_REV]
                     & (req_i.src_mac == flow_dst)
                     & (req_i.dst_mac == flow_src));

  // egress watch looks at the normal set before exclusion of mirror ports
  assign pm0_hit = pm0_en & (m0_egr ? (base_dest[m0_src] & ~drop_now)
                                    : (req_i.src_port == m0_src));
  assign pm1_hit = pm1_en & (m1_egr ? (base_dest[m1_src] & ~drop_now)
                                    : (req_i.src_port == m1_src));

  // address and flow copies share the first mirror slot's port
  assign mir_dest = (((addr_hit | flow_hit) | pm0_hit)
                     ? (16'h0001 << m0_dst) : 16'h0000)
                  | (pm1_hit ? (16'h0001 << m1_dst) : 16'h0000);

  // ---------------- result register ----------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_o <= '0;
    end else begin
      resp_o.valid   <= req_i.valid;
      resp_o.discard <= req_i.valid & drop_now;
      resp_o.mirror  <= req_i.valid & (mir_dest != 16'h0000);
      resp_o.dest    <= req_i.valid ? (norm_dest | mir_dest)
                                    : 16'h0000;
    end
  end

  // wrap-around counters give software a view of traffic and trunk drops
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= 16'h0000;
      drop_cnt  <= 16'h0000;
    end else if (req_i.valid) begin
      frame_cnt <= frame_cnt + 16'h0001;
      if (drop_now) begin
        drop_cnt <= drop_cnt + 16'h0001;
      end
    end
  end

endmodule // tms_select

// file: pkg/tms_pkg.sv
// package of constants and carrier types for the trunk and mirror selector
//
// Operation
// - eight aggregation groups, up to eight members each, local or cascaded ports
// - hash base is src+dst MAC, src MAC, dst MAC, or ring-only source port
// - unicast to an aggregation member fetches that port's group number
// - unicast whose ingress port is in the destination group is discarded
// - eight hash-indexed selection entries per group keep each flow on one port
// - multicast starts from the VLAN member port set
// - multicast removes the ingress port and its whole aggregation group
// - multicast keeps only the hash-selected member of every other group
// - software rewrites selection entries so survivors carry a failed link's load
// - address mirroring uses entry mirror flag and per-address source/destination choice
// - address mirror match on the chosen side copies the frame to mirror port
// - flow mirroring copies frames matching the programmed source/destination pair
// - separate enable also mirrors the reverse direction of the pair
// - any fast port mirrors onto any fast port, ingress or egress chosen
// - at most two mirror destination ports at once
// - mirror destination ports of enabled port-mirror slots carry only mirrored copies, no normal traffic
// - remote loopback is set up by mirroring a port's ingress onto itself
package tms_pkg;

  localparam int NPORT  = 16;
  localparam int NGROUP = 8;
  localparam int NENTRY = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PGRP_LO = 8'h04;
  localparam logic [7:0] OFS_PGRP_HI = 8'h08;
  localparam logic [7:0] OFS_MIRROR  = 8'h0C;
  localparam logic [7:0] OFS_FSRC_LO = 8'h10;
  localparam logic [7:0] OFS_FSRC_HI = 8'h14;
  localparam logic [7:0] OFS_FDST_LO = 8'h18;
  localparam logic [7:0] OFS_FDST_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_TBL     = 8'h40;

  // control register fields
  localparam int CTRL_HASH_LSB = 0;
  localparam int CTRL_RING     = 2;
  localparam int CTRL_FLOW_EN  = 3;
  localparam int CTRL_FLOW_REV = 4;
  localparam int CTRL_PM0_EN   = 5;
  localparam int CTRL_PM1_EN   = 6;
  localparam int CTRL_WIDTH    = 7;

  // mirror register fields, two 12-bit slots
  localparam int MIR_DST_LSB = 0;
  localparam int MIR_SRC_LSB = 4;
  localparam int MIR_EGRESS  = 8;
  localparam int MIR_SLOT    = 12;

  // port group nibble: member flag above the group number
  localparam int PGRP_MEMBER = 3;

  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_MIRROR = 32'h0000_0000;
  localparam logic [31:0] RST_PGRP   = 32'h0000_0000;
  localparam logic [31:0] RST_FLOW   = 32'h0000_0000;
  localparam logic [31:0] RST_TBL    = 32'h7654_3210;

  typedef enum logic [1:0] {
    TMS_HASH_BOTH = 2'b00,
    TMS_HASH_SRC  = 2'b01,
    TMS_HASH_DST  = 2'b10,
    TMS_HASH_PORT = 2'b11
  } tms_hash_t;

  typedef struct packed {
    logic        valid;
    logic        unicast;
    logic [3:0]  src_port;
    logic [47:0] src_mac;
    logic [47:0] dst_mac;
    logic [15:0] vlan_map;
    logic [3:0]  dst_port;
    logic        dst_trunk;
    logic        src_mirror;
    logic        src_side;
    logic        dst_mirror;
    logic        dst_side;
  } tms_req_t;

  typedef struct packed {
    logic        valid;
    logic        discard;
    logic        mirror;
    logic [15:0] dest;
  } tms_resp_t;

endpackage

// file: verif/tb.sv
// self-checking testbench for the trunk and mirror selector
`timescale 1ns/1ps
module tb;
  import tms_pkg::*;
  logic        mclk_i, rstn_i, cyc, stb, we, go, g1, wb_ack_o;
  logic [7:0]  adr;
  logic [3:0]  sel, wsel;
  logic [31:0] dat, wb_dat_o, ctrl, mir;
  logic [31:0] tbl [NGROUP];
  logic [63:0] pg;
  tms_req_t    req_d, req_i, rn;
  tms_resp_t   resp_o, e1;
  logic [31:0] rq [$];
  tms_resp_t   eq [$];
  int          err_count, n_tests, seen, disc;

  tms_select uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
    .resp_o(resp_o));
  tms_far_model u_far (.mclk_i(mclk_i), .rstn_i(rstn_i), .go_i(go),
    .req_d_i(req_d), .req_o(req_i));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  function automatic logic [2:0] fold(input logic [47:0] v);
    fold = 3'h0;
    for (int i = 0; i < 16; i++) fold ^= v[3*i +: 3];
  endfunction
  function automatic tms_resp_t expect_of(input tms_req_t r);
    logic [2:0] k;
    logic [3:0] g, d;
    logic [15:0] nm, cp, ex;
    logic [11:0] s;
    tms_resp_t e;
    k = fold(r.src_mac ^ r.dst_mac);
    if (ctrl[1:0] == 2'h1) k = fold(r.src_mac);
    if (ctrl[1:0] == 2'h2) k = fold(r.dst_mac);
    if (ctrl[1:0] == 2'h3 && ctrl[2]) k = r.src_port[2:0];
    e = '0;
    e.valid = 1'b1;
    g = pg[4*r.src_port +: 4];
    d = pg[4*r.dst_port +: 4];
    nm = 16'h1 << r.dst_port;
    if (!r.unicast) nm = r.vlan_map & ~(16'h1 << r.src_port);
    else if (r.dst_trunk && d[3]) begin
      nm = 16'h1 << tbl[d[2:0]][4*k +: 4];
      if (g == d) nm = 16'h0;
      e.discard = (g == d);
    end
    for (int i = 0; i < 16; i++)
      if (!r.unicast && pg[4*i+3]) begin
        if (g[3] && pg[4*i +: 3] == g[2:0]) nm[i] = 1'b0;
        if (tbl[pg[4*i +: 3]][4*k +: 4] != 4'(i)) nm[i] = 1'b0;
      end
    cp = 16'h0;
    ex = 16'h0;
    if ((r.src_mirror && r.src_side) || (r.dst_mirror && !r.dst_side))
      cp[mir[3:0]] = 1'b1;
    if (ctrl[3] && r.src_mac == 48'h1 && r.dst_mac == 48'h2)
      cp[mir[3:0]] = 1'b1;
    if (ctrl[4] && r.src_mac == 48'h2 && r.dst_mac == 48'h1)
      cp[mir[3:0]] = 1'b1;
    for (int i = 0; i < 2; i++) begin
      s = mir[12*i +: 12];
      if (ctrl[5+i]) ex[s[3:0]] = 1'b1;
      if (ctrl[5+i] && (s[8] ? nm[s[7:4]] : r.src_port == s[7:4]))
        cp[s[3:0]] = 1'b1;
    end
    e.dest = (nm & ~ex) | cp;
    e.mirror = |cp;
    return e;
  endfunction
  function automatic tms_req_t rnd_req();
    tms_req_t q;
    q = tms_req_t'(127'({$urandom(), $urandom(), $urandom(), $urandom()}));
    q.valid = 1'b1;
    q.dst_port[3] = q.dst_port[3] & q.dst_trunk;
    if ($urandom % 2) q.src_mac = 48'($urandom % 3);
    if ($urandom % 2) q.dst_mac = 48'($urandom % 3);
    if ($urandom % 4) q.src_mirror = 1'b0;
    if ($urandom % 4) q.dst_mirror = 1'b0;
    if (|q.vlan_map[2:0]) q.vlan_map[2:0] = 3'h7;
    if (|q.vlan_map[4:3]) q.vlan_map[4:3] = 2'h3;
    return q;
  endfunction

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (8000) @(posedge mclk_i);
    err_count++;
    summarize();
  end
  always @(posedge mclk_i) begin
    if (resp_o.valid === 1'b1)
      chk(32'(resp_o), eq.size() ? 32'(eq.pop_front()) : 32'hF);
    if (wb_ack_o === 1'b1 && we === 1'b0)
      chk(wb_dat_o, rq.size() ? rq.pop_front() : 32'hF);
  end

  initial begin
    {rstn_i, cyc, stb, we, go, adr, sel, dat} = '0;
    req_d = '0;
    wsel = 4'hF;
    {err_count, n_tests, seen, disc} = '0;
    {ctrl, mir} = '0;
    // ports 0-2 form group 0, ports 3-4 group 1
    pg = 64'h0000_0000_0009_9888;
    void'($urandom(32'h83aff173));
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_MIRROR, RST_MIRROR);
    rd(OFS_TBL + 8'h1C, RST_TBL);
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0);
    // single-lane write must leave the other lanes untouched
    wsel = 4'h2;
    wb(1'b1, OFS_PGRP_HI, 32'hFFFF_FFFF);
    wsel = 4'hF;
    rd(OFS_PGRP_HI, 32'h0000_FF00);
    wb(1'b1, OFS_PGRP_HI, 32'h0);
    wb(1'b1, OFS_FDST_HI, 32'hA5A5_1234);
    rd(OFS_FDST_HI, 32'h0000_1234);
    wb(1'b1, OFS_FDST_HI, 32'h0);
    wb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
    rd(OFS_CTRL, 32'h0000_007F);
    wb(1'b1, OFS_PGRP_LO, pg[31:0]);
    wb(1'b1, OFS_FSRC_LO, 32'h1);
    wb(1'b1, OFS_FDST_LO, 32'h2);
    for (int g = 0; g < NGROUP; g++) begin
      tbl[g] = (g == 1) ? 32'h4343_4343 : 32'h1021_0210;
      wb(1'b1, OFS_TBL + 8'(4*g), tbl[g]);
    end
    for (int ph = 0; ph < 5; ph++) begin
      // port 1 drops out of group 0 from here on
      if (ph == 1) tbl[0] = 32'h2020_2020;
      wb(1'b1, OFS_TBL, tbl[0]);
      mir = $urandom & 32'h001F_F1FF;
      if (ph == 2) mir[20:16] = {1'b0, mir[15:12]};
      ctrl = {25'h0, 4'($urandom), ph == 3, 2'(ph == 4 ? 3 : ph)};
      ctrl[6] = ctrl[6] | (ph == 2);
      wb(1'b1, OFS_CTRL, ctrl);
      wb(1'b1, OFS_MIRROR, mir);
      for (int i = 0; i < 150; i++) begin
        @(posedge mclk_i);
        rn = rnd_req();
        g1 = ($urandom % 4) != 0;
        go <= g1;
        req_d <= rn;
        if (g1) begin
          e1 = expect_of(rn);
          eq.push_back(e1);
          seen++;
          disc += e1.discard;
        end
      end
      @(posedge mclk_i);
      go <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
    rd(OFS_STATUS, {disc[15:0], seen[15:0]});
    repeat (4) @(posedge mclk_i);
    chk(32'(eq.size()), 32'h0);
    summarize();
  end
endmodule // tb

// file: verif/tms_far_model.sv
// search engine stand-in presenting lookups to the selector
`timescale 1ns/1ps
module tms_far_model
  import tms_pkg::*;
(
  input  wire logic     mclk_i,  // clock
  input  wire logic     rstn_i,  // reset, active low
  input  wire logic     go_i,    // present a lookup
  input  wire tms_req_t req_d_i, // lookup to present
  output tms_req_t      req_o    // selector request port
);
  // idle fields flip so unqualified use of them shows up
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) req_o <= '0;
    else if (go_i) req_o <= req_d_i;
    else req_o <= {1'b0, ~req_o[$bits(tms_req_t)-2:0]};
  end
endmodule // tms_far_model

// file: verif/tms_select_sva.sv
// concurrent checks on the selector's bus and lookup stream
`timescale 1ns/1ps
module tms_select_sva
  import tms_pkg::*;
(
  input wire logic        mclk_i,   // clock
  input wire logic        rstn_i,   // reset, active low
  input wire logic        wb_cyc_i, // cycle
  input wire logic        wb_stb_i, // strobe
  input wire logic        wb_we_i,  // write
  input wire logic [7:0]  wb_adr_i, // address
  input wire logic [3:0]  wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic        wb_ack_o, // ack
  input wire tms_req_t    req_i,    // lookup
  input wire tms_resp_t   resp_o    // decision
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mcast;
    req_i.valid && !req_i.unicast ##1 resp_o.valid && !resp_o.mirror;
  endsequence
  sequence s_ucast;
    req_i.valid && req_i.unicast ##1 resp_o.valid && !resp_o.mirror;
  endsequence
  AST_WB_ACK: assert property (s_wb_req |=> wb_ack_o)
    else $error("ack late");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_RESP_LAT: assert property (req_i.valid |=> resp_o.valid)
    else $error("no answer");
  AST_RESP_ONLY: assert property (!req_i.valid |=> !resp_o.valid)
    else $error("answer without lookup");
  AST_DISCARD: assert property (resp_o.valid && resp_o.discard
    |-> $past(req_i.unicast && req_i.dst_trunk)) else $error("bad drop");
  AST_MC_VLAN: assert property (s_mcast
    |-> (resp_o.dest & ~$past(req_i.vlan_map)) == 16'h0)
    else $error("port outside vlan");
  AST_MC_SRC: assert property (s_mcast
    |-> !resp_o.dest[$past(req_i.src_port)]) else $error("src kept");
  AST_UC_ONE: assert property (s_ucast |-> $onehot0(resp_o.dest))
    else $error("unicast fanout");
  AST_ADDR_MIR: assert property (req_i.valid && req_i.src_mirror
    && req_i.src_side |=> resp_o.mirror) else $error("no copy");
  AST_COPY_DEST: assert property (resp_o.valid && resp_o.mirror
    |-> resp_o.dest != 16'h0) else $error("copy lost");
endmodule // tms_select_sva

bind tms_select tms_select_sva u_sva (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .req_i(req_i), .resp_o(resp_o));
